/* src/sdram_addr_mux_read_capture.sv */
// address multiplexer and read capture of the memory side of the controller
// assumes internal bus on ref_clk; strobe and data pins come from the board
// What this block does
// - one memory technology, sdr or ddr, is served at a time
// - memory clock at most 133 MHz; ddr moves data on both edges
// - outputs 13 row, 12 column, 2 bank lines and 4 chip selects
// - two memory chip selects share pins with local bus selects
// - memory data bus is fixed at 32 bits
// - row plus column address bits stay below 24; the block still maps 24 or more and only raises geometryFault
// - one chip select reaches at most 2^26 words of 32 bits
// - module enable latches internal address bits 27 to 2
// - fixed fields: bits 9-2 column, 11-10 bank, 23-12 row
// - bits 27-24 carry extra row or column bits per geometry
// - each lane samples data a quarter clock after its strobe edge
// - in sdr mode the block drives its own looped back read strobe
`timescale 1ns/1ps
`default_nettype none
`include "sdram_mux_defs.svh"
module sdram_addr_mux_read_capture
    import sdram_mux_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire sdram_mux_pkg::mem_tech_t memTech,
    input  wire sdram_mux_pkg::geom_t   geometry,
    input  wire logic [1:0]             extraCols,
    input  wire logic                   moduleEnable,
    input  wire logic [31:0]            internalAddr,
    input  wire logic [1:0]             chipSelectReq,
    input  wire logic [1:0]             sharedPinForMemory,
    input  wire logic                   localBusCs2,
    input  wire logic                   localBusCs3,
    input  wire logic                   readActive,
    input  wire logic [3:0]             byte_lane_strobe_inputs,
    input  wire logic [31:0]            memDataIn,
    output sdram_mux_pkg::row_addr_t    row_addr,
    output sdram_mux_pkg::col_addr_t    col_addr,
    output logic [1:0]                  bankAddr,
    output logic [3:0]                  memChipSelect_n,
    output logic [1:0]                  sharedCsPin_n,
    output logic                        sdr_loopback_read_strobe,
    output sdram_mux_pkg::word_t        readData,
    output logic [3:0]                  readLaneValid,
    output logic                        geometryFault
);
    import sdram_mux_pkg::*;

    logic [25:0] addrHeld;
    logic [1:0]  csHeld;
    logic        addrValid;
    logic [3:0]  strobeMeta;
    logic [3:0]  strobeSync;
    word_t       dataMeta;
    word_t       dataSync;
    logic        ddrMode;
    logic        strobeToggle;
    logic [7:0]  laneBytes [4];
    row_addr_t   next_row;
    col_addr_t   next_col;
    logic [4:0]  rowCount;
    logic [4:0]  colCount;

    // column field: low byte fixed, bit 10 forced low for auto precharge
    function automatic col_addr_t map_col(input logic [25:0] a, input geom_t g,
                                          input logic [1:0] x);
        col_addr_t c;
        logic      r13;
        c = '0;
        r13 = g[1];
        c[7:0] = a[7:0];
        if (!r13) begin
            c[8] = a[22];
            if (g[0]) begin
                c[9] = a[23];
                c[11] = (x != 2'b00) ? a[24] : 1'b0;
                c[12-1] = c[11];
                if (x == 2'b10) begin
                    c[11] = a[24];
                end
            end
        end else if (g[0]) begin
            c[8] = a[23];
            c[9] = (x != 2'b00) ? a[24] : 1'b0;
            c[11] = (x == 2'b10) ? a[25] : 1'b0;
        end
        c[`AUTO_PRE_BIT] = 1'b0;
        return c;
    endfunction : map_col

    // width of a geometry, shared by the fault check and the assertion below
    function automatic logic [4:0] col_width(input geom_t g, input logic [1:0] x);
        logic [4:0] w;
        w = 5'h08;
        if (g == GEOM_R12_CX) begin
            w = 5'h0a + {3'h0, x};
        end else if (g == GEOM_R13_CX) begin
            w = 5'h09 + {3'h0, x};
        end
        return w;
    endfunction : col_width

    assign ddrMode  = (memTech == TECH_DDR);
    assign rowCount = geometry[1] ? 5'h0d : 5'h0c;
    assign colCount = col_width(geometry, extraCols);

    // more than 23 row plus column bits would pass 2^26 words per select
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            geometryFault <= 1'b0;
        end else begin
            geometryFault <= (rowCount + colCount) >= 5'(`GEOM_LIMIT);
        end
    end

    always_comb begin
        next_row = '0;
        next_row[11:0] = addrHeld[21:10];
        if (geometry[1]) begin
            next_row[12] = addrHeld[22];
        end
        next_col = map_col(addrHeld, geometry, extraCols);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addrHeld  <= 26'h0000000;
            csHeld    <= 2'h0;
            addrValid <= 1'b0;
        end else begin
            addrValid <= moduleEnable;
            if (moduleEnable) begin
                addrHeld <= internalAddr[27:`COL_LOW_LSB];
                csHeld   <= chipSelectReq;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            row_addr <= '0;
            col_addr <= '0;
            bankAddr <= 2'h0;
        end else if (addrValid) begin
            row_addr <= next_row;
            col_addr <= next_col;
            bankAddr <= addrHeld[9:8];
        end
    end

    // chip select 2 and 3 pins carry either memory or local bus selects
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            memChipSelect_n <= 4'hf;
            sharedCsPin_n   <= 2'h3;
        end else begin
            memChipSelect_n <= ~(addrValid ? (4'h1 << csHeld) : 4'h0);
            sharedCsPin_n[0] <= sharedPinForMemory[0] ?
                ~(addrValid && csHeld == 2'h2) : localBusCs2;
            sharedCsPin_n[1] <= sharedPinForMemory[1] ?
                ~(addrValid && csHeld == 2'h3) : localBusCs3;
        end
    end

    // pins are asynchronous to ref_clk, so two flops before any use
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strobeMeta <= 4'h0;
            strobeSync <= 4'h0;
            dataMeta   <= '0;
            dataSync   <= '0;
        end else begin
            strobeMeta <= byte_lane_strobe_inputs;
            strobeSync <= strobeMeta;
            dataMeta   <= memDataIn;
            dataSync   <= dataMeta;
        end
    end

    // sdr memories give no strobe; board loops this back with delay
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strobeToggle <= 1'b0;
        end else begin
            strobeToggle <= (!ddrMode && readActive) ? ~strobeToggle : 1'b0;
        end
    end
    assign sdr_loopback_read_strobe = strobeToggle;

    for (genvar lane = 0; lane < `LANE_COUNT; lane++) begin : g_lane
        lane_capture u_lane (
            .ref_clk    (ref_clk),
            .rst        (rst),
            .strobeSync (strobeSync[lane]),
            .dataSync   (dataSync[lane*8 +: 8]),
            .ddrMode    (ddrMode),
            .laneData   (laneBytes[lane]),
            .laneValid  (readLaneValid[lane])
        );
        assign readData[lane*8 +: 8] = laneBytes[lane];
    end

    addr_latch_a: assert property (@(posedge ref_clk) disable iff (rst)
        moduleEnable |=> addrHeld == $past(internalAddr[27:2]))
        else $error("address not latched on module enable");

    fixed_fields_a: assert property (@(posedge ref_clk) disable iff (rst)
        moduleEnable |=> ##1 bankAddr == $past(internalAddr[11:10], 2)
            && row_addr[11:0] == $past(internalAddr[23:12], 2)
            && col_addr[7:0] == $past(internalAddr[9:2], 2))
        else $error("fixed address fields wrong");

    row_extra_a: assert property (@(posedge ref_clk) disable iff (rst)
        addrValid && geometry[1] |=> row_addr[12] == $past(addrHeld[22]))
        else $error("row bit 12 not from address bit 24");

    col_extra_a: assert property (@(posedge ref_clk) disable iff (rst)
        addrValid && !geometry[1] |=> col_addr[8] == $past(addrHeld[22]))
        else $error("column bit 8 not from address bit 24");

    precharge_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
        col_addr[10] == 1'b0)
        else $error("column bit 10 driven from address");

    one_select_a: assert property (@(posedge ref_clk) disable iff (rst)
        $countones(~memChipSelect_n) <= 1)
        else $error("more than one memory select active");

    sdr_strobe_a: assert property (@(posedge ref_clk) disable iff (rst)
        ddrMode |=> !sdr_loopback_read_strobe)
        else $error("loopback strobe toggles in ddr mode");

    sdr_toggle_a: assert property (@(posedge ref_clk) disable iff (rst)
        !ddrMode && readActive |=> sdr_loopback_read_strobe != $past(sdr_loopback_read_strobe))
        else $error("loopback strobe not toggling during sdr read");

    geom_fault_a: assert property (@(posedge ref_clk) disable iff (rst)
        (rowCount + colCount) < 5'd24 |=> !geometryFault)
        else $error("legal geometry flagged as fault");
endmodule : sdram_addr_mux_read_capture
`default_nettype wire

/* src/sdram_mux_defs.svh */
// constants for the memory address multiplexer and read capture block
// assumes inclusion by src files only; definitions only
`ifndef SDRAM_MUX_DEFS_SVH
`define SDRAM_MUX_DEFS_SVH

`define ROW_BITS        13
`define COL_BITS        12
`define BANK_BITS       2
`define CS_COUNT        4
`define DATA_BITS       32
`define LANE_COUNT      4
`define GEOM_LIMIT      24
`define MAX_CLK_KHZ     133000
`define REF_CLK_KHZ     50000
`define REF_PERIOD_PS   20000
`define QUARTER_PS      (`REF_PERIOD_PS / 4)
`define QUARTER_CYCLES  ((`QUARTER_PS + `REF_PERIOD_PS - 1) / `REF_PERIOD_PS)
`define COL_LOW_LSB     2
`define BANK_LSB        10
`define ROW_LSB         12
`define EXTRA_LSB       24
`define AUTO_PRE_BIT    10
`define SHARED_CS_LSB   2

`endif

/* src/sdram_mux_pkg.sv */
// types shared by the multiplexer, the far side model and the bench
// assumes sdram_mux_defs.svh is on the include path
`include "sdram_mux_defs.svh"
package sdram_mux_pkg;
    typedef enum logic [0:0] {
        TECH_SDR = 1'b0,
        TECH_DDR = 1'b1
    } mem_tech_t;

    typedef enum logic [1:0] {
        GEOM_R12_C8  = 2'b00,
        GEOM_R12_CX  = 2'b01,
        GEOM_R13_C8  = 2'b10,
        GEOM_R13_CX  = 2'b11
    } geom_t;

    typedef logic [`ROW_BITS-1:0]  row_addr_t;
    typedef logic [`COL_BITS-1:0]  col_addr_t;
    typedef logic [`DATA_BITS-1:0] word_t;
endpackage : sdram_mux_pkg

/* src/lane_capture.sv */
// one byte lane read capture, delayed a quarter period after its strobe edge
// assumes strobe and data already synchronised to ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "sdram_mux_defs.svh"
module lane_capture (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       strobeSync,
    input  wire logic [7:0] dataSync,
    input  wire logic       ddrMode,
    output logic      [7:0] laneData,
    output logic            laneValid
);
    logic       strobeLast;
    logic       edgeSeen;
    logic [7:0] dataHeld;

    // sdr sees only rising edges; ddr samples on both
    assign edgeSeen = ddrMode ? (strobeSync ^ strobeLast) : (strobeSync & ~strobeLast);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strobeLast <= 1'b0;
        end else begin
            strobeLast <= strobeSync;
        end
    end

    // quarter period rounds up to one cycle at this clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dataHeld  <= 8'h00;
            laneData  <= 8'h00;
            laneValid <= 1'b0;
        end else begin
            dataHeld  <= dataSync;
            laneValid <= edgeSeen;
            if (edgeSeen) begin
                laneData <= dataHeld;
            end
        end
    end

    lane_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
        edgeSeen |=> laneValid && laneData == $past(dataHeld))
        else $error("lane capture not one quarter step after strobe");
endmodule : lane_capture
`default_nettype wire

/* testbench/sdram_far_side.sv */
// far side model: sdr strobe loop back on the board, or ddr memory driving strobes
// assumes the bench picks the technology and the word the memory returns on reads
`timescale 1ns/1ps
`default_nettype none
module sdram_far_side (
    input  wire logic                     ref_clk,
    input  wire sdram_mux_pkg::mem_tech_t memTech,
    input  wire logic                     readActive,
    input  wire logic                     loopStrobe,
    input  wire logic [31:0]              fillWord,
    output logic      [3:0]               strobePins,
    output logic      [31:0]              dataPins
);
    import sdram_mux_pkg::*;
    logic [31:0] lastWord;
    logic        ddrStrobe;
    initial begin
        lastWord = '0;
        ddrStrobe = 1'b0;
    end
    always @(posedge ref_clk) begin
        ddrStrobe <= (readActive && memTech == TECH_DDR) ? ~ddrStrobe : 1'b0;
        lastWord <= dataPins;
    end
    // the buffered loop back lands with or after the data, never before it
    assign strobePins = (memTech == TECH_DDR) ? {4{ddrStrobe}} : {4{loopStrobe}};
    // a released bus keeps changing so a stale word cannot pass for a capture
    assign dataPins = readActive ? fillWord : ~lastWord;
endmodule : sdram_far_side
`default_nettype wire

/* testbench/tb_sdram_addr_mux_read_capture.sv */
// self-checking bench for the address multiplexer and read capture block
// assumes the far side model loops the strobe back or acts as ddr memory
`timescale 1ns/1ps
`default_nettype none
module tb_sdram_addr_mux_read_capture;
    import sdram_mux_pkg::*;
    logic        ref_clk, rst, moduleEnable, localBusCs2, localBusCs3, readActive;
    logic        loopStrobe, geometryFault;
    mem_tech_t   memTech;
    geom_t       geometry;
    logic [1:0]  extraCols, chipSelectReq, sharedPinForMemory, bankAddr, sharedCsPin_n;
    logic [31:0] internalAddr, fillWord, dataPins;
    logic [3:0]  strobePins, memChipSelect_n, readLaneValid;
    row_addr_t   rowAddr;
    col_addr_t   colAddr;
    word_t       readData;
    int          fail_count = 0;
    int          cmp_count = 0;

    sdram_addr_mux_read_capture sdram_addr_mux_read_capture_inst (
        .ref_clk(ref_clk), .rst(rst), .memTech(memTech), .geometry(geometry),
        .extraCols(extraCols), .moduleEnable(moduleEnable), .internalAddr(internalAddr),
        .chipSelectReq(chipSelectReq), .sharedPinForMemory(sharedPinForMemory),
        .localBusCs2(localBusCs2), .localBusCs3(localBusCs3), .readActive(readActive),
        .byte_lane_strobe_inputs(strobePins), .memDataIn(dataPins), .row_addr(rowAddr),
        .col_addr(colAddr), .bankAddr(bankAddr), .memChipSelect_n(memChipSelect_n),
        .sharedCsPin_n(sharedCsPin_n), .sdr_loopback_read_strobe(loopStrobe),
        .readData(readData), .readLaneValid(readLaneValid), .geometryFault(geometryFault));

    sdram_far_side sdram_far_side_inst (
        .ref_clk(ref_clk), .memTech(memTech), .readActive(readActive),
        .loopStrobe(loopStrobe), .fillWord(fillWord), .strobePins(strobePins),
        .dataPins(dataPins));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    function automatic logic [12:0] exp_row(input geom_t g, input logic [31:0] a);
        exp_row = {(g[1] ? a[24] : 1'b0), a[23:12]};
    endfunction : exp_row

    // column bit 10 stays clear in every geometry: it carries auto precharge
    function automatic logic [11:0] exp_col(input geom_t g, input logic [1:0] x,
                                            input logic [31:0] a);
        exp_col = {4'h0, a[9:2]};
        // without a thirteenth row bit, bit 24 always feeds column bit 8
        if (!g[1]) exp_col[8] = a[24];
        if (g == GEOM_R12_CX) begin
            exp_col[8] = a[24];
            exp_col[9] = a[25];
            if (x != 2'd0) exp_col[11] = a[26];
        end
        if (g == GEOM_R13_CX) begin
            exp_col[8] = a[25];
            if (x != 2'd0) exp_col[9] = a[26];
        end
    endfunction : exp_col

    task automatic addr_case(input geom_t g, input logic [1:0] x, input logic [31:0] a,
                             input logic [1:0] cs);
        @(posedge ref_clk);
        geometry <= g;
        extraCols <= x;
        internalAddr <= a;
        chipSelectReq <= cs;
        moduleEnable <= 1'b1;
        @(posedge ref_clk);
        moduleEnable <= 1'b0;
        // fields and select come out one edge after the address is held
        @(posedge ref_clk);
        #1;
        check_val(rowAddr, exp_row(g, a));
        check_val(colAddr, exp_col(g, x, a));
        check_val(bankAddr, a[11:10]);
        check_val(memChipSelect_n, 4'(~(4'h1 << cs)));
        check_val(geometryFault, 1'b0);
        @(posedge ref_clk);
        #1 check_val(memChipSelect_n, 4'hf);
    endtask : addr_case

    task automatic shared_case(input logic c2, input logic c3);
        @(posedge ref_clk);
        sharedPinForMemory <= 2'b00;
        localBusCs2 <= c2;
        localBusCs3 <= c3;
        repeat (3) @(posedge ref_clk);
        #1 check_val(sharedCsPin_n, {c3, c2});
    endtask : shared_case

    // 12 rows with 12 columns reach 24 address bits, which is too many
    task automatic fault_case();
        @(posedge ref_clk);
        geometry <= GEOM_R12_CX;
        extraCols <= 2'd2;
        repeat (2) @(posedge ref_clk);
        #1 check_val(geometryFault, 1'b1);
    endtask : fault_case

    // counts lane captures and strobe toggles over a fixed read window
    task automatic read_case(input mem_tech_t t, input logic [31:0] w, input int lo,
                             input int hi);
        int n;
        int tog;
        logic prev;
        n = 0;
        tog = 0;
        @(posedge ref_clk);
        memTech <= t;
        fillWord <= w;
        repeat (6) @(posedge ref_clk);
        readActive <= 1'b1;
        prev = loopStrobe;
        for (int k = 0; k < 12; k++) begin
            @(posedge ref_clk);
            #1;
            if (loopStrobe !== prev) tog++;
            prev = loopStrobe;
            if (readLaneValid[0] === 1'b1) begin
                n++;
                check_val(readLaneValid, 4'hf);
                check_val(readData, w);
            end
        end
        check_val(n >= lo && n <= hi, 1'b1);
        check_val(tog, (t == TECH_SDR) ? 32'd12 : 32'd0);
        @(posedge ref_clk);
        readActive <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask : read_case

    initial begin
        rst = 1'b1;
        memTech = TECH_SDR;
        geometry = GEOM_R12_C8;
        {moduleEnable, readActive, extraCols, chipSelectReq} = '0;
        {internalAddr, fillWord, sharedPinForMemory} = '0;
        {localBusCs2, localBusCs3} = 2'b11;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        #1 check_val(memChipSelect_n, 4'hf);
        addr_case(GEOM_R12_C8, 2'd0, 32'h0fff_fffc, 2'd0);
        addr_case(GEOM_R12_CX, 2'd1, 32'h0fff_fffc, 2'd1);
        addr_case(GEOM_R13_C8, 2'd0, 32'h0a5a_5a54, 2'd0);
        addr_case(GEOM_R13_CX, 2'd1, 32'h05a5_a5a8, 2'd1);
        shared_case(1'b0, 1'b1);
        shared_case(1'b1, 1'b0);
        fault_case();
        read_case(TECH_SDR, 32'hc3a5_5a3c, 3, 6);
        read_case(TECH_DDR, 32'h1e2d_3c4b, 7, 12);
        read_case(TECH_SDR, 32'h8765_4321, 3, 6);
        end_of_test();
    end
endmodule : tb_sdram_addr_mux_read_capture
`default_nettype wire
